// [cmcs_pkg.sv]
// Constants, types and layouts for the cell monitor conversion sequencer
package cmcs_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int MEAS_MIN_NS = 1000;
	localparam int MEAS_MIN_CYC = (MEAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQ_STEP_NS = 500;
	localparam int ACQ_STEP_CYC = (ACQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQ_CNT_W = 8;

	// Sizes
	localparam int RES_W = 12;
	localparam int SUM_W = 15;
	localparam int N_CELL = 6;
	localparam int N_CH = 12;
	localparam int CH_W = 4;
	localparam int DATA_W = 16;

	// Serial frame: 32 bits, MSB first
	localparam logic [4:0] BIT_LAST = 5'h1F;
	localparam logic [4:0] BIT_TX_LOAD = 5'h0F;

	// Register indices
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_VHI = 8'h01;
	localparam logic [7:0] IDX_VLO = 8'h02;
	localparam logic [7:0] IDX_THI = 8'h03;
	localparam logic [7:0] IDX_TLO = 8'h04;
	localparam logic [7:0] IDX_BAL = 8'h05;
	localparam logic [7:0] IDX_STAT = 8'h06;
	localparam logic [7:0] IDX_RES0 = 8'h10;
	localparam logic [7:0] IDX_RES_LAST = 8'h1B;

	// Control fields
	localparam int CTRL_SEQ_HI = 15;
	localparam int CTRL_SEQ_LO = 14;
	localparam int CTRL_AVG_HI = 13;
	localparam int CTRL_AVG_LO = 12;
	localparam int CTRL_ACQ_HI = 11;
	localparam int CTRL_ACQ_LO = 10;
	localparam int CTRL_SWST = 9;

	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
	localparam logic [RES_W-1:0] THR_HI_RST = 12'hFFF;
	localparam logic [RES_W-1:0] THR_LO_RST = 12'h000;
	localparam logic [N_CELL-1:0] BAL_RST = 6'h00;
	localparam logic [2:0] PIN_IDLE = 3'h3;

	// Sequence choices and last channel of each
	localparam logic [1:0] SEQ_V6T3 = 2'h1;
	localparam logic [1:0] SEQ_V6 = 2'h2;
	localparam logic [CH_W-1:0] LAST_V6T6 = 4'hB;
	localparam logic [CH_W-1:0] LAST_V6T3 = 4'h8;
	localparam logic [CH_W-1:0] LAST_V6 = 4'h5;
	localparam logic [CH_W-1:0] CH_FIRST_T = 4'h6;

	typedef enum logic [3:0] {
		CMCS_IDLE = 4'h1,
		CMCS_ACQ = 4'h2,
		CMCS_CONV = 4'h4,
		CMCS_STORE = 4'h8
	} cmcs_state_t;

	typedef struct packed {
		logic [3:0] dev;
		logic wr;
		logic [2:0] rsvd;
		logic [7:0] idx;
		logic [DATA_W-1:0] data;
	} cmcs_cmd_t;

	typedef struct packed {
		logic temp;
		logic [2:0] sel;
		logic hold;
	} cmcs_mux_t;

endpackage : cmcs_pkg

// [cmcs_sequencer.sv]
// Conversion sequencer, daisy chain relay and serial register access of a six-cell monitor
//
// What this block does
// RQ1 - Pass data from upper serial input down to lower serial output.
// RQ2 - Repeat convert start input level onto upper convert start output.
// RQ3 - Relay host serial input onto upper serial output.
// RQ4 - Relay serial clock onto upper serial clock output.
// RQ5 - Relay active-low chip select onto upper select output.
// RQ6 - Relay power-down input onto upper power-down output.
// RQ7 - One start request runs the whole programmed sequence unaided.
// RQ8 - In software start mode, chip select rising edge starts a sequence.
// RQ9 - After reset the convert start pin triggers until software mode chosen.
// RQ10 - Three sequences: 6V+6T default, 6V+3T, or 6V only.
// RQ11 - Each measurement takes at least 1us acquisition plus conversion.
// RQ12 - Control option lengthens acquisition time.
// RQ13 - Optional averaging of 2, 4 or 8 conversions per channel.
// RQ14 - Reset gives no averaging and minimum 1us measurement time.
// RQ15 - Each channel result goes into its own result register.
// RQ16 - Host reads results only after the sequence has finished. Code serves result reads at any time, also while o_busy is high.
// RQ17 - Host reads and writes registers over the four-wire serial port.
// RQ18 - Alert when any result lies outside the programmed thresholds.
// RQ19 - Six independent cell-balance outputs, each low or high.
// RQ20 - Voltage conversions step through cell pairs from lowest upward.
// RQ21 - Temperature conversions select one of six thermistor inputs.
// RQ22 - Own alert combined with alert from above, passed downward.
// RQ23 - End of conversion advances mux, acquires, then starts next conversion.
// RQ24 - After the sequence the mux returns to the lowest cell pair.
// RQ25 - Sequence choice comes from the two top control bits.
// RQ26 - Start requests during a running sequence are ignored.
// RQ27 - Averaged result is the mean truncated to 12 bits.
`timescale 1ns/1ps
`default_nettype none

module cmcs_sequencer (
	input wire logic i_sys_clk, // 20 MHz system clock
	input wire logic i_rstn, // Reset, active low; synchronous on i_sys_clk, asynchronous for the held frame and link read flags (bit counter and shift registers clear on i_cs_n)
	input wire logic i_sclk, // Serial clock from below
	input wire logic i_cs_n, // Chip select, active low
	input wire logic i_sdi, // Serial data from below
	input wire logic i_upper_serial_in, // Serial data from device above
	output logic o_lower_serial_out, // Serial data toward host
	output logic o_upper_serial_out, // Serial data to device above
	output logic o_upper_serial_clock_out, // Serial clock to device above
	output logic o_upper_select_out_n, // Chip select to device above
	input wire logic i_convert_start_in_n, // Convert start, active low
	output logic o_upper_convert_start_out_n, // Convert start to device above
	input wire logic i_powerdown_in, // Power-down request
	output logic o_upper_powerdown_out, // Power-down to device above
	input wire logic i_upper_alert_in, // Alert from device above
	output logic o_lower_alert_out, // Chain alert toward host
	input wire logic [3:0] i_chain_addr, // Position of this device
	output cmcs_pkg::cmcs_mux_t o_mux, // Mux select and track/hold
	output logic o_adc_start, // Conversion start pulse
	input wire logic i_adc_done, // Conversion done pulse
	input wire logic [cmcs_pkg::RES_W-1:0] i_adc_data, // Conversion code
	output logic [cmcs_pkg::N_CELL-1:0] o_cell_balance, // Cell-balance drives
	output logic o_busy, // Sequence running
	output logic o_seq_done // One-cycle end of sequence
);

	// Daisy chain relays
	assign o_upper_serial_out = i_sdi; // RQ3
	assign o_upper_serial_clock_out = i_sclk; // RQ4
	assign o_upper_select_out_n = i_cs_n; // RQ5
	assign o_upper_convert_start_out_n = i_convert_start_in_n; // RQ2
	assign o_upper_powerdown_out = i_powerdown_in; // RQ6

	// Link side: frame receive and read return
	logic [4:0] bit_cnt_r;
	logic [31:0] rx_r;
	logic [31:0] rx_word;
	cmcs_pkg::cmcs_cmd_t cmd_hold_r;
	logic cmd_tgl_r;
	logic rd_own_l1_r;
	logic rd_own_l2_r;
	logic own_drv_r;
	logic [cmcs_pkg::DATA_W-1:0] tx_r;
	logic rd_own_r;
	logic [cmcs_pkg::DATA_W-1:0] rd_data_r;

	assign rx_word = {rx_r[30:0], i_sdi};

	always_ff @(posedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			bit_cnt_r <= '0;
			rx_r <= '0;
		end
		else
		begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
			rx_r <= rx_word;
		end
	end

	// Completed frame held until the next one completes
	always_ff @(posedge i_sclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cmd_hold_r <= '0;
			cmd_tgl_r <= 1'b0;
		end
		else if (!i_cs_n && bit_cnt_r == cmcs_pkg::BIT_LAST)
		begin
			cmd_hold_r <= rx_word; // RQ17
			cmd_tgl_r <= ~cmd_tgl_r;
		end
	end

	// Read flag into link domain
	always_ff @(posedge i_sclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rd_own_l1_r <= 1'b0;
			rd_own_l2_r <= 1'b0;
		end
		else
		begin
			rd_own_l1_r <= rd_own_r;
			rd_own_l2_r <= rd_own_l1_r;
		end
	end

	// Read data shifted out during the data half of the frame
	always_ff @(posedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			own_drv_r <= 1'b0;
			tx_r <= '0;
		end
		else if (bit_cnt_r == cmcs_pkg::BIT_TX_LOAD)
		begin
			own_drv_r <= rd_own_l2_r;
			tx_r <= rd_data_r; // RQ17
		end
		else
		begin
			if (bit_cnt_r == cmcs_pkg::BIT_LAST)
				own_drv_r <= 1'b0;
			tx_r <= {tx_r[14:0], 1'b0};
		end
	end

	assign o_lower_serial_out = own_drv_r ? tx_r[15] : i_upper_serial_in; // RQ1

	// Pin synchronisers: cs_n, convert start, power-down
	logic [2:0] pin_in;
	logic [2:0] pin_s1_r;
	logic [2:0] pin_s2_r;
	logic [2:0] pin_s3_r;
	logic [2:0] pin_f_r;
	logic [2:0] pin_f_d_r;

	assign pin_in = {i_powerdown_in, i_convert_start_in_n, i_cs_n};

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++)
		begin : g_pin
			always_ff @(posedge i_sys_clk)
			begin
				if (!i_rstn)
				begin
					pin_s1_r[gp] <= cmcs_pkg::PIN_IDLE[gp];
					pin_s2_r[gp] <= cmcs_pkg::PIN_IDLE[gp];
					pin_s3_r[gp] <= cmcs_pkg::PIN_IDLE[gp];
					pin_f_r[gp] <= cmcs_pkg::PIN_IDLE[gp];
					pin_f_d_r[gp] <= cmcs_pkg::PIN_IDLE[gp];
				end
				else
				begin
					pin_s1_r[gp] <= pin_in[gp];
					pin_s2_r[gp] <= pin_s1_r[gp];
					pin_s3_r[gp] <= pin_s2_r[gp];
					if (pin_s2_r[gp] == pin_s3_r[gp])
						pin_f_r[gp] <= pin_s3_r[gp];
					pin_f_d_r[gp] <= pin_f_r[gp];
				end
			end
		end
	endgenerate

	logic cs_rise;
	logic cnv_fall;
	logic pd_lvl;
	assign cs_rise = pin_f_r[0] & ~pin_f_d_r[0];
	assign cnv_fall = ~pin_f_r[1] & pin_f_d_r[1];
	assign pd_lvl = pin_f_r[2];

	// Command toggle into system domain
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;
	logic cmd_ev;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end
		else
		begin
			tgl_s1_r <= cmd_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end
	assign cmd_ev = tgl_s2_r ^ tgl_s3_r;

	// Register decode
	logic cmd_mine;
	logic wr_ev;
	logic rd_ev;
	assign cmd_mine = cmd_ev && (cmd_hold_r.dev == i_chain_addr);
	assign wr_ev = cmd_mine && cmd_hold_r.wr;
	assign rd_ev = cmd_mine && !cmd_hold_r.wr;

	logic [cmcs_pkg::DATA_W-1:0] ctrl_r;
	logic [cmcs_pkg::RES_W-1:0] vhi_r;
	logic [cmcs_pkg::RES_W-1:0] vlo_r;
	logic [cmcs_pkg::RES_W-1:0] thi_r;
	logic [cmcs_pkg::RES_W-1:0] tlo_r;
	logic [cmcs_pkg::N_CELL-1:0] bal_r;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			ctrl_r <= cmcs_pkg::CTRL_RST; // RQ9 RQ14
			vhi_r <= cmcs_pkg::THR_HI_RST;
			vlo_r <= cmcs_pkg::THR_LO_RST;
			thi_r <= cmcs_pkg::THR_HI_RST;
			tlo_r <= cmcs_pkg::THR_LO_RST;
			bal_r <= cmcs_pkg::BAL_RST;
		end
		else if (wr_ev)
		begin
			unique case (cmd_hold_r.idx)
				cmcs_pkg::IDX_CTRL: ctrl_r <= cmd_hold_r.data;
				cmcs_pkg::IDX_VHI: vhi_r <= cmd_hold_r.data[cmcs_pkg::RES_W-1:0]; // RQ18
				cmcs_pkg::IDX_VLO: vlo_r <= cmd_hold_r.data[cmcs_pkg::RES_W-1:0];
				cmcs_pkg::IDX_THI: thi_r <= cmd_hold_r.data[cmcs_pkg::RES_W-1:0];
				cmcs_pkg::IDX_TLO: tlo_r <= cmd_hold_r.data[cmcs_pkg::RES_W-1:0];
				cmcs_pkg::IDX_BAL: bal_r <= cmd_hold_r.data[cmcs_pkg::N_CELL-1:0]; // RQ19
				default: ;
			endcase
		end
	end

	assign o_cell_balance = bal_r; // RQ19

	// Control fields
	logic [1:0] seq_sel;
	logic [1:0] avg_sel;
	logic [1:0] acq_ext;
	logic sw_start;
	assign seq_sel = ctrl_r[cmcs_pkg::CTRL_SEQ_HI:cmcs_pkg::CTRL_SEQ_LO]; // RQ25
	assign avg_sel = ctrl_r[cmcs_pkg::CTRL_AVG_HI:cmcs_pkg::CTRL_AVG_LO];
	assign acq_ext = ctrl_r[cmcs_pkg::CTRL_ACQ_HI:cmcs_pkg::CTRL_ACQ_LO];
	assign sw_start = ctrl_r[cmcs_pkg::CTRL_SWST];

	logic [cmcs_pkg::CH_W-1:0] last_ch;
	assign last_ch = (seq_sel == cmcs_pkg::SEQ_V6) ? cmcs_pkg::LAST_V6 :
		(seq_sel == cmcs_pkg::SEQ_V6T3) ? cmcs_pkg::LAST_V6T3 : cmcs_pkg::LAST_V6T6; // RQ10

	logic [cmcs_pkg::ACQ_CNT_W-1:0] acq_need;
	assign acq_need = cmcs_pkg::ACQ_CNT_W'(cmcs_pkg::MEAS_MIN_CYC)
		+ cmcs_pkg::ACQ_CNT_W'(acq_ext) * cmcs_pkg::ACQ_CNT_W'(cmcs_pkg::ACQ_STEP_CYC); // RQ12

	logic [3:0] n_samp_m1;
	assign n_samp_m1 = 4'((4'h1 << avg_sel) - 4'h1); // RQ13

	// Sequencer state
	cmcs_pkg::cmcs_state_t state_r;
	cmcs_pkg::cmcs_state_t state_nxt;
	logic [cmcs_pkg::CH_W-1:0] ch_r;
	logic [cmcs_pkg::CH_W-1:0] ch_nxt;
	logic [cmcs_pkg::ACQ_CNT_W-1:0] acq_cnt_r;
	logic [cmcs_pkg::ACQ_CNT_W-1:0] acq_cnt_nxt;
	logic [3:0] samp_r;
	logic [3:0] samp_nxt;
	logic [cmcs_pkg::SUM_W-1:0] sum_r;
	logic [cmcs_pkg::SUM_W-1:0] sum_nxt;
	logic [cmcs_pkg::SUM_W-1:0] sum_shift;
	logic [cmcs_pkg::RES_W-1:0] mean;
	logic acq_ok;
	logic trig;

	assign acq_ok = acq_cnt_r >= acq_need; // RQ11
	assign trig = sw_start ? cs_rise : cnv_fall; // RQ8 RQ9
	assign sum_shift = sum_r >> avg_sel;
	assign mean = sum_shift[cmcs_pkg::RES_W-1:0]; // RQ27

	always_comb
	begin
		state_nxt = state_r;
		ch_nxt = ch_r;
		samp_nxt = samp_r;
		sum_nxt = sum_r;
		acq_cnt_nxt = (acq_cnt_r == '1) ? acq_cnt_r : acq_cnt_r + 8'h01;
		unique case (state_r)
			cmcs_pkg::CMCS_IDLE:
			begin
				// Start only from idle; requests while busy fall here unseen
				if (trig && !pd_lvl)
				begin
					state_nxt = cmcs_pkg::CMCS_ACQ; // RQ7 RQ26
					samp_nxt = '0;
					sum_nxt = '0;
				end
			end
			cmcs_pkg::CMCS_ACQ:
			begin
				if (acq_ok)
					state_nxt = cmcs_pkg::CMCS_CONV; // RQ23
			end
			cmcs_pkg::CMCS_CONV:
			begin
				acq_cnt_nxt = '0;
				if (i_adc_done)
				begin
					sum_nxt = sum_r + cmcs_pkg::SUM_W'(i_adc_data); // RQ13
					if (samp_r == n_samp_m1)
						state_nxt = cmcs_pkg::CMCS_STORE;
					else
					begin
						samp_nxt = samp_r + 4'h1;
						state_nxt = cmcs_pkg::CMCS_ACQ;
					end
				end
			end
			cmcs_pkg::CMCS_STORE:
			begin
				acq_cnt_nxt = '0;
				samp_nxt = '0;
				sum_nxt = '0;
				if (ch_r == last_ch)
				begin
					ch_nxt = '0; // RQ24
					state_nxt = cmcs_pkg::CMCS_IDLE;
				end
				else
				begin
					ch_nxt = ch_r + 4'h1; // RQ20 RQ21 RQ23
					state_nxt = cmcs_pkg::CMCS_ACQ;
				end
			end
		endcase
	end

	// Mux drive follows the next channel
	cmcs_pkg::cmcs_mux_t mux_nxt;
	logic [cmcs_pkg::CH_W-1:0] t_ch;
	assign t_ch = ch_nxt - cmcs_pkg::CH_FIRST_T;
	assign mux_nxt.temp = ch_nxt >= cmcs_pkg::CH_FIRST_T;
	assign mux_nxt.sel = mux_nxt.temp ? t_ch[2:0] : ch_nxt[2:0]; // RQ20 RQ21
	assign mux_nxt.hold = state_nxt == cmcs_pkg::CMCS_CONV;

	cmcs_pkg::cmcs_mux_t mux_r;
	logic start_r;
	logic done_r;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			state_r <= cmcs_pkg::CMCS_IDLE;
			ch_r <= '0;
			acq_cnt_r <= '0;
			samp_r <= '0;
			sum_r <= '0;
			mux_r <= '0;
			start_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			ch_r <= ch_nxt;
			acq_cnt_r <= acq_cnt_nxt;
			samp_r <= samp_nxt;
			sum_r <= sum_nxt;
			mux_r <= mux_nxt;
			start_r <= (state_r == cmcs_pkg::CMCS_ACQ) && acq_ok; // RQ23
			done_r <= (state_r == cmcs_pkg::CMCS_STORE) && (ch_r == last_ch);
		end
	end

	assign o_mux = mux_r;
	assign o_adc_start = start_r;
	assign o_seq_done = done_r;
	assign o_busy = state_r != cmcs_pkg::CMCS_IDLE;

	// Result registers
	logic [cmcs_pkg::RES_W-1:0] res_r [cmcs_pkg::N_CH];
	logic [cmcs_pkg::N_CH-1:0] res_vld_r;
	logic [cmcs_pkg::N_CH-1:0] out_rng;

	genvar gc;
	generate
		for (gc = 0; gc < cmcs_pkg::N_CH; gc++)
		begin : g_ch
			always_ff @(posedge i_sys_clk)
			begin
				if (!i_rstn)
				begin
					res_r[gc] <= '0;
					res_vld_r[gc] <= 1'b0;
				end
				else if (state_r == cmcs_pkg::CMCS_STORE && ch_r == gc)
				begin
					res_r[gc] <= mean; // RQ15
					res_vld_r[gc] <= 1'b1;
				end
			end
			if (gc < cmcs_pkg::N_CELL)
			begin : g_v
				assign out_rng[gc] = res_vld_r[gc] && (res_r[gc] > vhi_r || res_r[gc] < vlo_r);
			end
			else
			begin : g_t
				assign out_rng[gc] = res_vld_r[gc] && (res_r[gc] > thi_r || res_r[gc] < tlo_r);
			end
		end
	endgenerate

	logic own_alert_r;
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
			own_alert_r <= 1'b0;
		else
			own_alert_r <= |out_rng; // RQ18
	end
	assign o_lower_alert_out = own_alert_r | i_upper_alert_in; // RQ22

	// Read return, stable between frames
	logic [7:0] rd_res_i;
	logic [cmcs_pkg::DATA_W-1:0] rd_mux;
	assign rd_res_i = cmd_hold_r.idx - cmcs_pkg::IDX_RES0;
	assign rd_mux =
		(cmd_hold_r.idx == cmcs_pkg::IDX_CTRL) ? ctrl_r :
		(cmd_hold_r.idx == cmcs_pkg::IDX_VHI) ? {4'h0, vhi_r} :
		(cmd_hold_r.idx == cmcs_pkg::IDX_VLO) ? {4'h0, vlo_r} :
		(cmd_hold_r.idx == cmcs_pkg::IDX_THI) ? {4'h0, thi_r} :
		(cmd_hold_r.idx == cmcs_pkg::IDX_TLO) ? {4'h0, tlo_r} :
		(cmd_hold_r.idx == cmcs_pkg::IDX_BAL) ? {10'h000, bal_r} :
		(cmd_hold_r.idx == cmcs_pkg::IDX_STAT) ? {14'h0000, own_alert_r, o_busy} :
		(cmd_hold_r.idx >= cmcs_pkg::IDX_RES0 && cmd_hold_r.idx <= cmcs_pkg::IDX_RES_LAST)
			? {4'h0, res_r[rd_res_i[3:0]]} : 16'h0000;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			rd_own_r <= 1'b0;
			rd_data_r <= '0;
		end
		else if (cmd_ev)
		begin
			rd_own_r <= rd_ev; // RQ17
			if (rd_ev)
				rd_data_r <= rd_mux;
		end
	end

	// Checks
	localparam int MIN_CYC = cmcs_pkg::MEAS_MIN_CYC;

	a_busy_trig_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ26
		(state_r == cmcs_pkg::CMCS_ACQ && trig) |=> (ch_r == $past(ch_r)))
		else $error("start request changed channel while busy");

	a_seq_back_low: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ24
		(state_r == cmcs_pkg::CMCS_STORE && ch_r == last_ch)
		|=> (state_r == cmcs_pkg::CMCS_IDLE && ch_r == 4'h0 && !o_mux.temp && o_mux.sel == 3'h0))
		else $error("mux not back on lowest pair after sequence");

	a_acq_min_time: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ11
		(state_r == cmcs_pkg::CMCS_ACQ && state_nxt == cmcs_pkg::CMCS_CONV)
		|-> (acq_cnt_r >= 8'(MIN_CYC)))
		else $error("conversion started before minimum acquisition");

	a_start_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ23
		o_adc_start |-> (o_mux.hold ##1 !o_adc_start))
		else $error("start pulse without hold or longer than one cycle");

	a_chan_step_up: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ20
		(state_r == cmcs_pkg::CMCS_STORE && ch_r != last_ch)
		|=> (ch_r == $past(ch_r) + 4'h1 && state_r == cmcs_pkg::CMCS_ACQ))
		else $error("channel did not step upward");

	a_result_store: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ15
		(state_r == cmcs_pkg::CMCS_STORE) |=> (res_r[$past(ch_r)] == $past(mean)))
		else $error("result not written to its own register");

	a_pin_start: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ9
		(!sw_start && cnv_fall && state_r == cmcs_pkg::CMCS_IDLE && !pd_lvl)
		|=> (state_r == cmcs_pkg::CMCS_ACQ))
		else $error("convert start pin did not start a sequence");

	a_cs_start: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ8
		(sw_start && cs_rise && state_r == cmcs_pkg::CMCS_IDLE && !pd_lvl)
		|=> (state_r == cmcs_pkg::CMCS_ACQ))
		else $error("chip select rise did not start a sequence");

	a_alert_chain: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RQ22
		(i_upper_alert_in || own_alert_r) |-> o_lower_alert_out)
		else $error("alert not passed downward");

endmodule : cmcs_sequencer

`default_nettype wire

// [cmcs_host_model.sv]
// Host side serial master model for the cell monitor chain
`timescale 1ns/1ps
`default_nettype none

module cmcs_host_model (
	output logic o_sclk, // Serial clock, still between frames
	output logic o_cs_n, // Chip select, active low
	output logic o_sdi, // Serial data toward device
	input wire logic i_sdo // Serial data from device
);

	initial
	begin
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		// Raised after time zero so the frame clear sees a real edge
		#1;
		o_cs_n = 1'b1;
	end

	// One 32-bit frame, MSB first; keeps the last 16 bits seen
	task automatic xfer(input logic [31:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		#37;
		o_cs_n = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			o_sdi = tx[i];
			#62.5;
			if (i < 16)
				rx = {rx[14:0], i_sdo};
			o_sclk = 1'b1;
			#62.5;
			o_sclk = 1'b0;
		end
		o_cs_n = 1'b1;
		// Released line shows no stale level
		o_sdi = ~o_sdi;
		#400;
	endtask : xfer

endmodule : cmcs_host_model
`default_nettype wire

// [tb.sv]
// Self-checking bench for the cell monitor conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk, rstn, usi, cnv_n, pd, ua, done, jit, sclk, cs_n, sdi;
	logic lso, uso, uck, ucs_n, ucv_n, upd, lal, ast, busy, sdone;
	logic [11:0] data;
	logic [5:0] bal;
	logic [3:0] ch;
	logic [15:0] rx, v;
	cmcs_pkg::cmcs_mux_t mux;
	int fail_count, check_count, starts, gap, min_gap, dcnt;
	logic [3:0] ord[$];
	logic [7:0] rows [6] = '{8'h99, 8'hEE, 8'h66, 8'h55, 8'hFF, 8'h88};
	logic [11:0] thr [4] = '{12'h140, 12'h120, 12'h1A0, 12'h170};
	int nch [4] = '{12, 9, 6, 12};

	cmcs_sequencer i_cmcs_sequencer (
		.i_sys_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
		.i_upper_serial_in(usi), .o_lower_serial_out(lso), .o_upper_serial_out(uso),
		.o_upper_serial_clock_out(uck), .o_upper_select_out_n(ucs_n),
		.i_convert_start_in_n(cnv_n), .o_upper_convert_start_out_n(ucv_n),
		.i_powerdown_in(pd), .o_upper_powerdown_out(upd), .i_upper_alert_in(ua),
		.o_lower_alert_out(lal), .i_chain_addr(4'h0), .o_mux(mux), .o_adc_start(ast),
		.i_adc_done(done), .i_adc_data(data), .o_cell_balance(bal), .o_busy(busy),
		.o_seq_done(sdone)
	);

	cmcs_host_model i_cmcs_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(lso));

	assign ch = mux.temp ? {1'b0, mux.sel} + 4'h6 : {1'b0, mux.sel};

	// Converter core: done four cycles after start, code tied to channel
	always @(negedge clk)
	begin
		done <= 1'b0;
		gap <= gap + 1;
		if (dcnt > 0)
			dcnt <= dcnt - 1;
		if (ast === 1'b1)
		begin
			starts <= starts + 1;
			ord.push_back(ch);
			if (gap < min_gap)
				min_gap <= gap;
			dcnt <= 4;
		end
		else if (dcnt == 1)
		begin
			done <= 1'b1;
			data <= 12'h100 + {4'h0, ch, 4'h0} + {11'h0, jit & starts[0]};
			gap <= 0;
			if (busy === 1'b1)
				chk("hold", 16'h1, {15'h0, mux.hold});
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		i_cmcs_host_model.xfer({4'h0, 1'b1, 3'h0, idx, d}, rx);
	endtask : wr

	task automatic rd(input logic [7:0] idx, output logic [15:0] q);
		i_cmcs_host_model.xfer({4'h0, 1'b0, 3'h0, idx, 16'h0000}, rx);
		i_cmcs_host_model.xfer(32'hF0000000, q);
	endtask : rd

	task automatic pulse();
		@(negedge clk);
		cnv_n = 1'b0;
		repeat (8) @(negedge clk);
		cnv_n = 1'b1;
	endtask : pulse

	// One triggered sequence: count, channel order, spacing, idle return
	task automatic run(input logic sw, input int n, input int reps, input int ext, input logic again);
		int k;
		int need;
		need = cmcs_pkg::MEAS_MIN_CYC + ext * cmcs_pkg::ACQ_STEP_CYC;
		@(posedge clk);
		starts = 0;
		gap = 999;
		min_gap = 999;
		ord.delete();
		if (sw)
			i_cmcs_host_model.xfer(32'hF0000000, rx);
		else
			pulse();
		if (again)
		begin
			repeat (100) @(negedge clk);
			pulse();
		end
		for (k = 0; k < 5000 && sdone !== 1'b1; k++)
			@(negedge clk);
		chk("seq done", 16'h1, {15'h0, sdone});
		chk("conversions", 16'(n * reps), 16'(starts));
		for (k = 0; k < ord.size(); k++)
			chk("channel", 16'(k / reps), {12'h0, ord[k]});
		chk("spacing", 16'h1, {15'h0, min_gap >= need});
		repeat (2) @(negedge clk);
		chk("idle mux", 16'h0, {10'h0, mux, busy});
	endtask : run

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	initial
	begin
		#2000000;
		fail_count++;
		results();
	end

	initial
	begin
		fail_count = 0;
		check_count = 0;
		{cnv_n, pd, ua, usi, jit, done, dcnt, data} = {4'b1000, 2'b00, 32'h0, 12'h000};
		// Lowered after time zero so the link's reset sees a real edge
		#1;
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		// Pin levels against relayed outputs; start refused while powered down
		for (int r = 0; r < 6; r++)
		begin
			{cnv_n, pd, ua, usi} = rows[r][7:4];
			repeat (6) @(negedge clk);
			chk("relay", {11'h0, rows[r][3:0], 1'b0}, {11'h0, ucv_n, upd, lal, lso, busy});
			chk("link relay", {13'h0, sclk, cs_n, sdi}, {13'h0, uck, ucs_n, uso});
		end
		chk("reset outputs", 16'h0, {5'h0, mux, bal});
		rd(8'h00, v);
		chk("ctrl reset", 16'h0000, v);
		run(1'b0, 12, 1, 0, 1'b1);
		for (int c = 0; c < 12; c++)
		begin
			rd(8'h10 + 8'(c), v);
			chk("result", 16'h0100 + 16'(c * 16), v);
		end
		for (int s = 1; s < 4; s++)
		begin
			wr(8'h00, {2'(s), 14'h0000});
			run(1'b0, nch[s], 1, 0, 1'b0);
		end
		jit = 1'b1;
		for (int a = 1; a < 4; a++)
		begin
			wr(8'h00, {2'h2, 2'(a), 12'h000});
			run(1'b0, 6, 1 << a, 0, 1'b0);
			rd(8'h15, v);
			chk("mean", 16'h0150, v);
		end
		jit = 1'b0;
		wr(8'h00, 16'h8C00);
		run(1'b0, 6, 1, 3, 1'b0);
		for (int t = 0; t < 4; t++)
		begin
			wr(8'(t + 1), {4'h0, thr[t]});
			repeat (4) @(negedge clk);
			chk("alert set", 16'h1, {15'h0, lal});
			wr(8'(t + 1), (t % 2 == 0) ? 16'h0FFF : 16'h0000);
			repeat (4) @(negedge clk);
			chk("alert clear", 16'h0, {15'h0, lal});
		end
		wr(8'h05, 16'h002A);
		chk("balance", 16'h002A, {10'h0, bal});
		wr(8'h05, 16'h0015);
		chk("balance", 16'h0015, {10'h0, bal});
		rd(8'h00, v);
		chk("ctrl read", 16'h8C00, v);
		rd(8'h30, v);
		chk("unmapped", 16'h0000, v);
		wr(8'h00, 16'h0200);
		repeat (600) @(negedge clk);
		run(1'b1, 12, 1, 0, 1'b0);
		// Reset in mid-sequence: outputs and control back to defaults
		wr(8'h05, 16'h003F);
		chk("busy", 16'h1, {15'h0, busy});
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		chk("mid-run reset", 16'h0, {4'h0, busy, mux, bal});
		rd(8'h00, v);
		chk("ctrl after reset", 16'h0000, v);
		results();
	end

endmodule : tb
`default_nettype wire
